// ===== design/rsc_regs.svh
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH

// register byte offsets
`define RSC_PERIOD_OFFSET   8'h00
`define RSC_STATUS_OFFSET   8'h04
`define RSC_ADDR_W          8

// watchdog period field
`define RSC_PERIOD_W        3
`define RSC_PERIOD_RESET    3'h7
`define RSC_PERIOD_BASE_EXP 8

// status register field positions
`define RSC_STAT_TIMEOUT    0
`define RSC_STAT_POWERDOWN  1
`define RSC_STAT_CAUSE_LSB  2
`define RSC_STAT_CAUSE_MSB  6

// cause codes, one-hot
`define RSC_CAUSE_POWERON   5'h01
`define RSC_CAUSE_PIN       5'h02
`define RSC_CAUSE_LOWSUPPLY 5'h04
`define RSC_CAUSE_WDT_RUN   5'h08
`define RSC_CAUSE_WDT_SLEEP 5'h10

// timing
`define RSC_CLK_KHZ         40000
`define RSC_RESET_DELAY_MS  100
`define RSC_LVR_QUALIFY_US  1000
`define RSC_SST_LONG        32'h0000_0400
`define RSC_SST_SHORT       32'h0000_0002

// axi responses
`define RSC_RESP_OKAY       2'h0
`define RSC_RESP_DECERR     2'h3

`endif

// ===== design/rsc_pkg.sv
package rsc_pkg;

    typedef enum logic [3:0] {
        RSC_HOLD  = 4'h1,
        RSC_DELAY = 4'h2,
        RSC_START = 4'h4,
        RSC_RUN   = 4'h8
    } rsc_phase_e;

    typedef logic [4:0] rsc_cause_t;

    // static configuration options
    typedef struct packed {
        logic       low_supply_enable;
        logic [1:0] low_supply_threshold;
        logic       rc_clock_source;
        logic       short_startup;
    } rsc_config_s;

    // reset actions toward the core
    typedef struct packed {
        logic pc_clear;
        logic sp_clear;
        logic io_preset;
        logic warm_reset;
    } rsc_action_s;

    typedef struct packed {
        logic        pin_meta;
        logic        pin_sync;
        logic        lv_meta;
        logic        lv_sync;
        rsc_phase_e  phase;
        logic [31:0] count;
        logic [31:0] lv_count;
        logic [2:0]  period;
        logic        timeout_flag;
        logic        powerdown_flag;
        rsc_cause_t  cause;
        rsc_action_s act;
        logic        wdt_restart;
        logic [1:0]  threshold;
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic        w_strb0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } rsc_state_s;

endpackage

// ===== design/rsc_wdt_counter.sv
`include "rsc_regs.svh"

module rsc_wdt_counter #(
    parameter int CODE_W   = `RSC_PERIOD_W,
    parameter int BASE_EXP = `RSC_PERIOD_BASE_EXP
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // control
    input  wire logic              tick,
    input  wire logic              restart,
    input  wire logic [CODE_W-1:0] period,
    // event
    output logic                   timeout
);

    localparam int CNT_W = BASE_EXP + (1 << CODE_W) - 1;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic             timeout;
    } rsc_wdt_s;

    rsc_wdt_s         s;
    rsc_wdt_s         next_s;
    logic [CNT_W-1:0] terminal;

    assign terminal = {CNT_W{1'b1}} >> (~period);

    always_comb
    begin
        next_s = s;
        next_s.timeout = 1'b0;
        if (restart)
        begin
            next_s.count = '0;
        end
        else if (tick)
        begin
            // >= so a shortened period still expires
            if (s.count >= terminal)
            begin
                next_s.count = '0;
                next_s.timeout = 1'b1;
            end
            else
            begin
                next_s.count = s.count + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign timeout = s.timeout;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_wdt_expire: assert property (tick && !restart && s.count >= terminal |=> timeout)
        else $error("watchdog missed its period");
    a_wdt_early: assert property (tick && !restart && s.count < terminal |=> !timeout)
        else $error("watchdog expired early");

endmodule // rsc_wdt_counter

// ===== design/rsc_reset_control.sv
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`include "rsc_regs.svh"

// Behaviour
// - period register bits 7..3 read zero, writes to them ignored.
// - period code selects 2^8..2^15 watchdog clocks, each step doubling.
// - power-on reset clears the program counter.
// - power-on reset presets all port data and direction registers to ones.
// - after pin release wait the reset delay; execution held meanwhile.
// - pin pulled low while running clears program counter and restarts.
// - pin reset keeps a defined subset of registers unchanged.
// - five reset sources, each leaving its own register state.
// - low-supply reset acts only when enabled by configuration.
// - low supply must persist past qualify time before reset fires.
// - qualified low supply acts like a pin reset.
// - low-supply threshold chosen by configuration, not a register.
// - watchdog expiry while running acts like pin reset, sets timeout flag.
// - watchdog expiry in sleep clears only pc and sp, sets timeout flag.
// - cause flags: power-on 00, pin/low unchanged, run 1u, sleep 11.
// - start-up timer 1024 or 2 cycles with RC, 1024 with crystal.
module rsc_reset_control #(
    parameter int RESET_DELAY_CYCLES = `RSC_RESET_DELAY_MS * `RSC_CLK_KHZ,
    parameter int LVR_QUALIFY_CYCLES = (`RSC_LVR_QUALIFY_US * `RSC_CLK_KHZ + 999) / 1000
) (
    // clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // axi4-lite write
    input  wire logic [7:0]            awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    // axi4-lite read
    input  wire logic [7:0]            araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    // pins and analog
    input  wire logic                  external_reset_pin_n,
    input  wire logic                  low_supply_detect,
    output logic [1:0]                 low_supply_threshold,
    // configuration options
    input  wire rsc_pkg::rsc_config_s  cfg,
    // core side
    input  wire logic                  sleep_mode,
    input  wire logic                  halt_exec,
    input  wire logic                  wdt_clear,
    input  wire logic                  wdt_enable,
    input  wire logic                  wdt_tick,
    output rsc_pkg::rsc_action_s       action,
    output logic                       cpu_run,
    output logic                       timeout_flag,
    output logic                       powerdown_flag
);

    rsc_pkg::rsc_state_s s;
    rsc_pkg::rsc_state_s next_s;
    logic                wdt_timeout;
    logic                lv_fire;
    logic                lv_active;
    logic                full_evt;
    logic [31:0]         sst_cycles;
    logic [31:0]         rd_word;
    logic                rd_hit;

    // watchdog counter shares the period field
    rsc_wdt_counter #(
        .CODE_W   (`RSC_PERIOD_W),
        .BASE_EXP (`RSC_PERIOD_BASE_EXP)
    ) rsc_wdt_counter_inst (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (wdt_tick && wdt_enable && s.phase == rsc_pkg::RSC_RUN),
        .restart (s.wdt_restart || wdt_clear || halt_exec),
        .period  (s.period),
        .timeout (wdt_timeout)
    );

    // short start-up only with rc clock
    assign sst_cycles = (cfg.rc_clock_source && cfg.short_startup) ? `RSC_SST_SHORT
                                                                   : `RSC_SST_LONG;

    // qualify only while enabled, fire once
    assign lv_active = s.lv_count == 32'(LVR_QUALIFY_CYCLES);
    assign lv_fire = cfg.low_supply_enable && s.lv_sync
                     && s.lv_count == 32'(LVR_QUALIFY_CYCLES - 1);
    assign full_evt = (!s.pin_sync && s.phase != rsc_pkg::RSC_HOLD) || lv_fire
                      || (wdt_timeout && s.phase == rsc_pkg::RSC_RUN);

    // read mux; upper period bits read zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        if ({araddr[7:2], 2'h0} == `RSC_PERIOD_OFFSET)
        begin
            rd_word[`RSC_PERIOD_W-1:0] = s.period;
        end
        else if ({araddr[7:2], 2'h0} == `RSC_STATUS_OFFSET)
        begin
            rd_word[`RSC_STAT_TIMEOUT] = s.timeout_flag;
            rd_word[`RSC_STAT_POWERDOWN] = s.powerdown_flag;
            rd_word[`RSC_STAT_CAUSE_MSB:`RSC_STAT_CAUSE_LSB] = s.cause;
        end
        else
        begin
            rd_hit = 1'b0;
        end
    end

    always_comb
    begin
        next_s = s;
        next_s.pin_meta = external_reset_pin_n;
        next_s.pin_sync = s.pin_meta;
        next_s.lv_meta = low_supply_detect;
        next_s.lv_sync = s.lv_meta;
        next_s.act = '0;
        next_s.wdt_restart = 1'b0;
        next_s.threshold = cfg.low_supply_threshold;

        // short dips reset the qualify count
        if (!cfg.low_supply_enable || !s.lv_sync)
        begin
            next_s.lv_count = 32'h0000_0000;
        end
        else if (!lv_active)
        begin
            next_s.lv_count = s.lv_count + 32'h0000_0001;
        end

        // write channel
        if (awvalid && awready)
        begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = awaddr;
        end
        if (wvalid && wready)
        begin
            next_s.w_held = 1'b1;
            next_s.w_data = wdata;
            next_s.w_strb0 = wstrb[0];
        end
        if (s.aw_held && s.w_held)
        begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = `RSC_RESP_OKAY;
            if ({s.aw_addr[7:2], 2'h0} == `RSC_PERIOD_OFFSET)
            begin
                // only the low field is stored
                if (s.w_strb0)
                begin
                    next_s.period = s.w_data[`RSC_PERIOD_W-1:0];
                end
            end
            else if ({s.aw_addr[7:2], 2'h0} != `RSC_STATUS_OFFSET)
            begin
                next_s.bresp = `RSC_RESP_DECERR;
            end
        end
        if (s.bvalid && bready)
        begin
            next_s.bvalid = 1'b0;
        end

        // read channel
        if (arvalid && arready)
        begin
            next_s.rvalid = 1'b1;
            next_s.rdata = rd_word;
            next_s.rresp = rd_hit ? `RSC_RESP_OKAY : `RSC_RESP_DECERR;
        end
        else if (s.rvalid && rready)
        begin
            next_s.rvalid = 1'b0;
        end

        // core flag events; halt set wins over clear
        if (wdt_clear)
        begin
            next_s.powerdown_flag = 1'b0;
        end
        if (halt_exec)
        begin
            next_s.powerdown_flag = 1'b1;
        end

        case (s.phase)
            rsc_pkg::RSC_HOLD:
            begin
                if (s.pin_sync && !lv_active)
                begin
                    next_s.phase = rsc_pkg::RSC_DELAY;
                    next_s.count = 32'h0000_0000;
                end
            end
            rsc_pkg::RSC_DELAY:
            begin
                if (s.count == 32'(RESET_DELAY_CYCLES - 1))
                begin
                    next_s.phase = rsc_pkg::RSC_START;
                    next_s.count = 32'h0000_0000;
                end
                else
                begin
                    next_s.count = s.count + 32'h0000_0001;
                end
            end
            rsc_pkg::RSC_START:
            begin
                if (s.count == sst_cycles - 32'h0000_0001)
                begin
                    next_s.phase = rsc_pkg::RSC_RUN;
                    next_s.count = 32'h0000_0000;
                end
                else
                begin
                    next_s.count = s.count + 32'h0000_0001;
                end
            end
            rsc_pkg::RSC_RUN:
            begin
                next_s.count = 32'h0000_0000;
            end
            default:
            begin
                next_s.phase = rsc_pkg::RSC_HOLD;
            end
        endcase

        // reset sources other than sleep expiry override any bus write in the same cycle
        if (full_evt && !(wdt_timeout && sleep_mode && s.pin_sync && !lv_fire))
        begin
            // warm reset keeps core registers, presets the rest
            next_s.act.pc_clear = 1'b1;
            next_s.act.sp_clear = 1'b1;
            next_s.act.io_preset = 1'b1;
            next_s.act.warm_reset = 1'b1;
            next_s.wdt_restart = 1'b1;
            next_s.period = `RSC_PERIOD_RESET;
            next_s.count = 32'h0000_0000;
            // pin and low supply leave both flags
            next_s.timeout_flag = s.timeout_flag;
            next_s.powerdown_flag = s.powerdown_flag;
            if (!s.pin_sync && s.phase != rsc_pkg::RSC_HOLD)
            begin
                next_s.phase = rsc_pkg::RSC_HOLD;
                next_s.cause = `RSC_CAUSE_PIN;
            end
            else if (lv_fire)
            begin
                next_s.phase = rsc_pkg::RSC_HOLD;
                next_s.cause = `RSC_CAUSE_LOWSUPPLY;
            end
            else
            begin
                // like pin reset but timeout flag set
                next_s.phase = rsc_pkg::RSC_DELAY;
                next_s.cause = `RSC_CAUSE_WDT_RUN;
                next_s.timeout_flag = 1'b1;
            end
        end
        else if (full_evt)
        begin
            // sleep expiry touches pc, sp and flags, then reruns the start-up timer
            next_s.act.pc_clear = 1'b1;
            next_s.act.sp_clear = 1'b1;
            next_s.wdt_restart = 1'b1;
            next_s.timeout_flag = 1'b1;
            next_s.powerdown_flag = 1'b1;
            next_s.cause = `RSC_CAUSE_WDT_SLEEP;
            next_s.phase = rsc_pkg::RSC_START;
            next_s.count = 32'h0000_0000;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '0;
            s.phase <= rsc_pkg::RSC_HOLD;
            s.period <= `RSC_PERIOD_RESET;
            s.cause <= `RSC_CAUSE_POWERON;
            s.act <= 4'hF;
            s.wdt_restart <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    // bus handshakes; one write and one read in flight
    assign awready = !s.aw_held && !s.bvalid;
    assign wready = !s.w_held && !s.bvalid;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = !s.rvalid;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign action = s.act;
    assign cpu_run = s.phase == rsc_pkg::RSC_RUN;
    assign timeout_flag = s.timeout_flag;
    assign powerdown_flag = s.powerdown_flag;
    assign low_supply_threshold = s.threshold;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_upper_bits_zero: assert property (rvalid |-> rdata[31:7] == 25'h0)
        else $error("reserved read bits not zero");
    a_period_write: assert property ($rose(s.bvalid) && s.bresp == `RSC_RESP_OKAY
        && s.aw_addr == `RSC_PERIOD_OFFSET && $past(s.w_strb0) && !$past(full_evt)
        |-> s.period == $past(s.w_data[2:0]))
        else $error("period write not stored");
    a_poweron_state: assert property ($rose(aresetn) |-> action == 4'hF && !cpu_run
        && s.period == `RSC_PERIOD_RESET && !timeout_flag && !powerdown_flag)
        else $error("power-on state wrong");
    a_delay_length: assert property (s.phase == rsc_pkg::RSC_START
        && $past(s.phase) == rsc_pkg::RSC_DELAY && !$past(full_evt)
        |-> $past(s.count) == 32'(RESET_DELAY_CYCLES - 1))
        else $error("reset delay length wrong");
    a_delay_holds: assert property (s.phase == rsc_pkg::RSC_DELAY |=> !cpu_run)
        else $error("execution during delay");
    a_pin_restart: assert property (cpu_run && !s.pin_sync
        |=> action.pc_clear && s.phase == rsc_pkg::RSC_HOLD ##1 !action.pc_clear)
        else $error("pin reset did not clear pc");
    a_pin_flags: assert property (cpu_run && !s.pin_sync && !halt_exec && !wdt_clear
        |=> $stable(timeout_flag) && $stable(powerdown_flag))
        else $error("pin reset changed flags");
    a_lv_disabled: assert property (!cfg.low_supply_enable && s.pin_sync
        && !wdt_timeout |=> !action.warm_reset)
        else $error("low supply fired while disabled");
    a_lv_qualify: assert property (lv_fire |-> $past(s.lv_sync, 1) && s.lv_sync
        && s.lv_count == 32'(LVR_QUALIFY_CYCLES - 1))
        else $error("low supply not qualified");
    a_wdt_run: assert property (wdt_timeout && cpu_run && !sleep_mode && s.pin_sync && !lv_fire
        |=> timeout_flag && action.io_preset && s.phase == rsc_pkg::RSC_DELAY)
        else $error("run expiry wrong");
    a_wdt_sleep: assert property (wdt_timeout && cpu_run && sleep_mode && s.pin_sync && !lv_fire
        |=> action.pc_clear && action.sp_clear && !action.io_preset && timeout_flag
        && powerdown_flag && $stable(s.period) && s.phase == rsc_pkg::RSC_START)
        else $error("sleep expiry wrong");
    a_startup_length: assert property (cpu_run && $past(s.phase) == rsc_pkg::RSC_START
        |-> $past(s.count) == $past(sst_cycles) - 32'h0000_0001)
        else $error("start-up length wrong");

    c_reach_run: cover property (s.phase == rsc_pkg::RSC_START ##1 cpu_run);
    c_wdt_sleep: cover property (wdt_timeout && cpu_run && sleep_mode);
    c_lv_fire: cover property (lv_fire);
    c_period_write: cover property ($rose(s.bvalid) && s.aw_addr == `RSC_PERIOD_OFFSET);

endmodule // rsc_reset_control

// ===== test/rsc_pin_model.sv
module rsc_pin_model
(
    // clock
    input  wire logic       aclk,
    // press command from the bench
    input  wire logic       press,
    input  wire logic [7:0] press_len,
    // reset pin, pulled up on the board
    output logic            pin_n
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] left = 8'h00;

    // a switch held for press_len cycles; once released the pull-up wins
    always @(posedge aclk)
    begin
        if (press)
            left <= press_len;
        else if (left != 8'h00)
            left <= left - 8'h01;
    end

    assign pin_n = (left == 8'h00);
endmodule // rsc_pin_model

// ===== test/tb_top.sv
`include "rsc_regs.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int         RST_DLY = 20;
    localparam int         LV_QUAL = 8;
    localparam logic [7:0] PER     = `RSC_PERIOD_OFFSET;
    localparam logic [7:0] STA     = `RSC_STATUS_OFFSET;
    localparam logic [1:0] OK      = `RSC_RESP_OKAY;
    localparam logic [1:0] DE      = `RSC_RESP_DECERR;

    logic                 aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic                 arvalid, arready, rvalid, rready, pin_n, lv_det, sleep_mode;
    logic                 halt_exec, wdt_clear, wdt_enable, wdt_tick, cpu_run, press;
    logic                 to_flag, pd_flag;
    logic [7:0]           awaddr, araddr, press_len;
    logic [31:0]          wdata, rdata;
    logic [3:0]           wstrb, last_act;
    logic [1:0]           bresp, rresp, lv_thr;
    rsc_pkg::rsc_config_s cfg;
    rsc_pkg::rsc_action_s action;
    int                   n_errors, n_compared, cycles, act_cnt, base, n;

    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // short delay and qualify counts keep the run brief
    rsc_reset_control #(.RESET_DELAY_CYCLES(RST_DLY), .LVR_QUALIFY_CYCLES(LV_QUAL))
    rsc_reset_control_inst (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .external_reset_pin_n(pin_n), .low_supply_detect(lv_det),
        .low_supply_threshold(lv_thr), .cfg(cfg),
        .sleep_mode(sleep_mode), .halt_exec(halt_exec), .wdt_clear(wdt_clear),
        .wdt_enable(wdt_enable), .wdt_tick(wdt_tick), .action(action),
        .cpu_run(cpu_run), .timeout_flag(to_flag), .powerdown_flag(pd_flag)
    );

    rsc_pin_model rsc_pin_model_inst (
        .aclk(aclk), .press(press), .press_len(press_len), .pin_n(pin_n)
    );

    // action pulses last one cycle, so keep the last one and a count
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (action != 4'h0)
        begin
            last_act <= action;
            act_cnt <= act_cnt + 1;
        end
        if (cycles == 12000)
        begin
            n_errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // bready and rready stay high, so an answer is taken where it is seen
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            if (!aw_ok && awready)
            begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready)
            begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid) @(posedge aclk);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        @(posedge aclk);
        while (!arready) @(posedge aclk);
        arvalid <= 1'b0;
        @(posedge aclk);
        while (!rvalid) @(posedge aclk);
        chk("rdata", ed, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask

    task automatic wait_run(output int c);
        c = 0;
        while (cpu_run !== 1'b1 && c < 3000)
        begin
            @(posedge aclk);
            c++;
        end
        chk("cpu_run", 32'h1, cpu_run);
    endtask

    // one tick every six cycles leaves room for the reset pulse to show
    task automatic wdt_count(output int k);
        base = act_cnt;
        k = 0;
        while (act_cnt == base && k < 700)
        begin
            wdt_tick <= 1'b1;
            @(posedge aclk);
            wdt_tick <= 1'b0;
            repeat (5) @(posedge aclk);
            k++;
        end
    endtask

    initial
    begin
        {aresetn, awvalid, wvalid, arvalid, lv_det, sleep_mode, halt_exec} = 7'h00;
        {wdt_clear, wdt_enable, wdt_tick, press} = 4'h0;
        {bready, rready} = 2'h3;
        {awaddr, araddr, press_len, wstrb} = 28'h0;
        wdata = 32'h0;
        cfg = '{1'b0, 2'h2, 1'b1, 1'b1};
        {n_errors, n_compared, cycles, act_cnt} = 128'h0;
        last_act = 4'h0;
        repeat (3) @(posedge aclk);
        chk("act_por", 32'hF, action);
        chk("flags_por", 32'h0, {to_flag, pd_flag});
        aresetn <= 1'b1;
        wait_run(n);
        chk("run_delay", 32'h1, n >= RST_DLY + 2 && n <= RST_DLY + 12);
        chk("threshold", 32'h2, lv_thr);
        rd(PER, 32'h7, OK);
        rd(STA, 32'h04, OK);
        wr(PER, 32'hFFFF_FFFA, 4'hF, OK);
        rd(PER, 32'h2, OK);
        wr(PER, 32'h5, 4'hE, OK);
        rd(PER, 32'h2, OK);
        wr(8'h08, 32'h1, 4'hF, DE);
        rd(8'h08, 32'h0, DE);
        wr(STA, 32'hFF, 4'hF, OK);
        rd(STA, 32'h04, OK);
        // watchdog expiry while running, shortest period
        wr(PER, 32'h0, 4'hF, OK);
        wdt_enable <= 1'b1;
        wdt_clear <= 1'b1;
        @(posedge aclk);
        wdt_clear <= 1'b0;
        wdt_count(n);
        chk("wdt_ticks", 32'd256, n);
        chk("wdt_act", 32'hF, last_act);
        chk("to_run", 32'h1, to_flag);
        wait_run(n);
        rd(STA, 32'h21, OK);
        rd(PER, 32'h7, OK);
        // pin pulled low while running
        base = act_cnt;
        press <= 1'b1;
        press_len <= 8'd10;
        @(posedge aclk);
        press <= 1'b0;
        repeat (6) @(posedge aclk);
        chk("run_in_pin", 32'h0, cpu_run);
        wait_run(n);
        chk("pin_acts", 32'h1, act_cnt - base);
        chk("pin_act", 32'hF, last_act);
        rd(STA, 32'h09, OK);
        // low supply, first disabled, then short and long dips
        base = act_cnt;
        lv_det <= 1'b1;
        repeat (16) @(posedge aclk);
        lv_det <= 1'b0;
        cfg.low_supply_enable <= 1'b1;
        repeat (5) @(posedge aclk);
        chk("lv_off", 32'h0, act_cnt - base);
        lv_det <= 1'b1;
        repeat (5) @(posedge aclk);
        lv_det <= 1'b0;
        repeat (6) @(posedge aclk);
        chk("lv_short", 32'h0, act_cnt - base);
        lv_det <= 1'b1;
        repeat (14) @(posedge aclk);
        lv_det <= 1'b0;
        wait_run(n);
        chk("lv_acts", 32'h1, act_cnt - base);
        chk("lv_act", 32'hF, last_act);
        rd(STA, 32'h11, OK);
        // watchdog expiry in sleep, one step longer period
        wr(PER, 32'h1, 4'hF, OK);
        wdt_clear <= 1'b1;
        @(posedge aclk);
        wdt_clear <= 1'b0;
        halt_exec <= 1'b1;
        @(posedge aclk);
        halt_exec <= 1'b0;
        sleep_mode <= 1'b1;
        @(posedge aclk);
        chk("pd_halt", 32'h1, pd_flag);
        wdt_count(n);
        chk("sleep_ticks", 32'd512, n);
        chk("sleep_act", 32'hC, last_act);
        chk("sleep_flags", 32'h3, {to_flag, pd_flag});
        sleep_mode <= 1'b0;
        wait_run(n);
        rd(PER, 32'h1, OK);
        rd(STA, 32'h43, OK);
        // second power-on with a crystal clock: long start-up, flags cleared
        cfg.rc_clock_source <= 1'b0;
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        wait_run(n);
        chk("run_xtal", 32'h1, n >= RST_DLY + 1024 && n <= RST_DLY + 1034);
        rd(STA, 32'h04, OK);
        rd(PER, 32'h7, OK);
        report_and_stop();
    end
endmodule // tb_top
